// >>> src/cdt_consts.svh
// Constants for the data-transfer decode and execute block
`ifndef CDT_CONSTS_SVH
`define CDT_CONSTS_SVH
// Instruction word fields
`define CDT_F_OP_HI   15
`define CDT_F_OP_LO   12
`define CDT_F_DST_HI  11
`define CDT_F_DST_LO  8
`define CDT_F_SRC_HI  7
`define CDT_F_SRC_LO  4
`define CDT_F_SUB_HI  3
`define CDT_F_SUB_LO  0
// Major opcodes of the group
`define CDT_OPC_IDX   4'h0
`define CDT_OPC_STL   4'h1
`define CDT_OPC_IND   4'h2
`define CDT_OPC_LDL   4'h5
`define CDT_OPC_REG   4'h6
`define CDT_OPC_DSP   4'h8
`define CDT_OPC_PCW   4'h9
`define CDT_OPC_PCL   4'hD
`define CDT_OPC_IMM   4'hE
// Sub codes
`define CDT_SUB_COPY  4'h3
`define CDT_DSP_ST    2'h0
`define CDT_DSP_LD    2'h1
// Reset values and timing
`define CDT_GPR_RST   32'h00000000
`define CDT_FLAGS_RST 32'h00000000
`define CDT_MIN_STATES 1
`endif

// >>> src/cdt_pkg.sv
// Types shared by the data-transfer decode and execute block
`default_nettype none
package cdt_pkg;
   typedef enum logic [1:0] {
      CDT_SIZE_BYTE = 2'h0,
      CDT_SIZE_WORD = 2'h1,
      CDT_SIZE_LONG = 2'h2
   } cdt_size_t;
   typedef enum logic [2:0] {
      CDT_K_NONE  = 3'h0,
      CDT_K_IMM   = 3'h1,
      CDT_K_COPY  = 3'h2,
      CDT_K_LOAD  = 3'h3,
      CDT_K_STORE = 3'h4
   } cdt_kind_t;
   typedef enum logic [2:0] {
      CDT_ST_IDLE = 3'h1,
      CDT_ST_WAIT = 3'h2,
      CDT_ST_MEM  = 3'h4
   } cdt_st_t;
   typedef struct packed {
      logic        legal;
      cdt_kind_t   kind;
      cdt_size_t   size;
      logic [3:0]  dst;
      logic [3:0]  src;
      logic [3:0]  base;
      logic        pc_base;
      logic        add_zero;
      logic        pre_dec;
      logic        post_inc;
      logic [31:0] disp;
      logic [15:0] rd_mask;
   } cdt_dec_t;
   typedef struct packed {
      cdt_st_t          st;
      logic [15:0][31:0] gpr;
      logic [31:0]      flags;
      cdt_dec_t         op;
      logic             req;
      logic             we;
      logic [31:0]      addr;
      cdt_size_t        size;
      logic [31:0]      wdata;
      logic             haz_v;
      logic [3:0]       haz_reg;
      logic             done;
      logic             illegal;
      logic [31:0]      view;
      logic [15:0]      stall_cnt;
   } cdt_core_t;
endpackage
`default_nettype wire

// >>> src/cdt_dec_if.sv
// Carrier between the core and its instruction decoder
`timescale 1ns/100ps
`default_nettype none
interface cdt_dec_if;
   import cdt_pkg::*;
   logic [15:0] word;
   cdt_dec_t    dec;
   modport decoder (input word, output dec);
   modport core (output word, input dec);
endinterface
`default_nettype wire

// >>> src/cdt_decode.sv
// Combinational decoder for the data-transfer instruction group
`timescale 1ns/100ps
`default_nettype none
`include "cdt_consts.svh"
module cdt_decode (
   // Decoded instruction carrier
   cdt_dec_if.decoder dbus
);
   import cdt_pkg::*;
   logic [3:0] opc;
   logic [3:0] fn;
   logic [3:0] fm;
   logic [3:0] sub;
   logic [7:0] d8;
   cdt_dec_t   d;
   assign opc = dbus.word[`CDT_F_OP_HI:`CDT_F_OP_LO];
   assign fn = dbus.word[`CDT_F_DST_HI:`CDT_F_DST_LO];
   assign fm = dbus.word[`CDT_F_SRC_HI:`CDT_F_SRC_LO];
   assign sub = dbus.word[`CDT_F_SUB_HI:`CDT_F_SUB_LO];
   assign d8 = dbus.word[7:0];
   always_comb begin
      d = '0;
      d.kind = CDT_K_NONE;
      d.size = CDT_SIZE_LONG;
      d.dst = fn;
      d.src = fm;
      d.base = fn;
      case (opc)
         `CDT_OPC_IMM: begin
            d.kind = CDT_K_IMM;
            d.disp = {{24{d8[7]}}, d8};
         end
         `CDT_OPC_PCW, `CDT_OPC_PCL: begin
            d.kind = CDT_K_LOAD;
            d.pc_base = 1'b1;
            d.size = (opc == `CDT_OPC_PCW) ? CDT_SIZE_WORD : CDT_SIZE_LONG;
            d.disp = {24'h000000, d8} << d.size;
         end
         `CDT_OPC_REG: begin
            if (sub == `CDT_SUB_COPY) begin
               d.kind = CDT_K_COPY;
            end else if (!sub[3] && sub[1:0] != 2'h3) begin
               d.kind = CDT_K_LOAD;
               d.size = cdt_size_t'(sub[1:0]);
               d.base = fm;
               d.post_inc = sub[2];
            end
         end
         `CDT_OPC_IND: begin
            if (!sub[3] && sub[1:0] != 2'h3) begin
               d.kind = CDT_K_STORE;
               d.size = cdt_size_t'(sub[1:0]);
               d.pre_dec = sub[2];
            end
         end
         `CDT_OPC_IDX: begin
            if (sub[3:2] == 2'h1 && sub[1:0] != 2'h3) begin
               d.kind = CDT_K_STORE;
               d.size = cdt_size_t'(sub[1:0]);
               d.add_zero = 1'b1;
            end
         end
         `CDT_OPC_STL, `CDT_OPC_LDL: begin
            d.kind = (opc == `CDT_OPC_STL) ? CDT_K_STORE : CDT_K_LOAD;
            d.base = (opc == `CDT_OPC_STL) ? fn : fm;
            d.disp = {28'h0000000, sub} << 2;
         end
         `CDT_OPC_DSP: begin
            if (!fn[1] && (fn[3:2] == `CDT_DSP_ST || fn[3:2] == `CDT_DSP_LD)) begin
               d.kind = (fn[3:2] == `CDT_DSP_ST) ? CDT_K_STORE : CDT_K_LOAD;
               d.size = fn[0] ? CDT_SIZE_WORD : CDT_SIZE_BYTE;
               d.base = fm;
               d.src = 4'h0;
               d.dst = 4'h0;
               d.disp = {28'h0000000, sub} << d.size;
            end
         end
         default: d.kind = CDT_K_NONE;
      endcase
      d.legal = (d.kind != CDT_K_NONE);
      if (d.kind == CDT_K_STORE || d.kind == CDT_K_COPY)
         d.rd_mask = d.rd_mask | (16'h0001 << d.src);
      if ((d.kind == CDT_K_STORE || d.kind == CDT_K_LOAD) && !d.pc_base)
         d.rd_mask = d.rd_mask | (16'h0001 << d.base);
      if (d.add_zero)
         d.rd_mask = d.rd_mask | 16'h0001;
   end
   assign dbus.dec = d;
endmodule
`default_nettype wire

// >>> src/cdt_core.sv
// Execute unit for the data-transfer instruction group with its register bank
//
// Contract
// - Sixteen-bit word; four-bit fields pick one of sixteen general registers.
// - Size suffix sets access width and address step.
// - Displacement scaled by one, two or four before adding to base.
// - One state minimum; fetch contention on the bus lengthens it.
// - One stall when the next instruction reads a just-loaded register.
// - Bus wait states stretch execution beyond the minimum.
// - No transfer here changes the condition flag.
// - Immediate form loads sign-extended eight-bit value.
// - PC-relative word load at PC plus twice displacement, sign-extended.
// - PC-relative longword load at PC plus four times displacement.
// - Register-indirect loads of byte, word, longword; short data sign-extended.
// - Pre-decrement stores drop base by size, then write source there.
// - Post-increment loads bump source at issue, then read and sign-extend short data.
// - Byte and word stores of register zero at base plus scaled displacement.
// - Longword store at destination plus four times displacement.
// - Byte and word loads into register zero, sign-extended.
// - Longword load at source plus four times displacement.
// - Indexed stores at register zero plus destination register.
`timescale 1ns/100ps
`default_nettype none
`include "cdt_consts.svh"
module cdt_core (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          nrst,
   // Instruction issue
   input  wire logic          instr_valid,
   input  wire logic [15:0]   instr_word,
   input  wire logic [31:0]   instr_pc,
   output logic               instr_ready,
   // Retirement
   output logic               instr_done,
   output logic               instr_illegal,
   // Data memory bus
   output logic               mem_req,
   output logic               mem_we,
   output logic [31:0]        mem_addr,
   output cdt_pkg::cdt_size_t mem_size,
   output logic [31:0]        mem_wdata,
   input  wire logic          mem_ack,
   input  wire logic [31:0]   mem_rdata,
   input  wire logic          fetch_busy,
   // Flags word, owned by the other instruction groups
   input  wire logic          flags_wr,
   input  wire logic [31:0]   flags_wdata,
   output logic [31:0]        flags_word,
   // Register view
   input  wire logic [3:0]    view_sel,
   output logic [31:0]        view_data,
   // Stall status
   output logic               data_stall,
   output logic [15:0]        stall_count
);
   import cdt_pkg::*;

   cdt_core_t   st_ff;
   cdt_core_t   nxt_st;
   cdt_dec_t    d;
   logic [31:0] base_val;
   logic [31:0] step;
   logic [31:0] offset;
   logic [31:0] eff_addr;
   logic        uses_haz;
   logic        hazard;
   logic        take;
   logic        stall_now;

   cdt_dec_if dec_bus ();

   cdt_decode u_dec (
      .dbus (dec_bus.decoder)
   );

   assign dec_bus.word = instr_word;
   assign d = dec_bus.dec;

   // Short loads come back right-aligned and are widened by sign
   function automatic logic [31:0] cdt_sext(input logic [31:0] v, input cdt_size_t s);
      logic [31:0] r;
      r = v;
      if (s == CDT_SIZE_BYTE) begin
         r = {{24{v[7]}}, v[7:0]};
      end else if (s == CDT_SIZE_WORD) begin
         r = {{16{v[15]}}, v[15:0]};
      end
      return r;
   endfunction

   // Address generation for the word on offer
   always_comb begin
      base_val = d.pc_base ? instr_pc : st_ff.gpr[d.base];
      step = 32'h00000001 << d.size;
      offset = d.add_zero ? st_ff.gpr[0] : d.disp;
      if (d.pre_dec) begin
         eff_addr = base_val - step;
      end else begin
         eff_addr = base_val + offset;
      end
   end

   // Load-use interlock: a register loaded in the last cycle is not read yet
   assign uses_haz = |(d.rd_mask & (16'h0001 << st_ff.haz_reg));
   assign hazard = st_ff.haz_v && uses_haz;
   assign instr_ready = (st_ff.st == CDT_ST_IDLE) && !hazard;
   assign take = instr_valid && instr_ready;

   assign stall_now = (st_ff.st == CDT_ST_IDLE && instr_valid && hazard)
                    || (st_ff.st == CDT_ST_WAIT)
                    || (st_ff.st == CDT_ST_MEM && !mem_ack);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.illegal = 1'b0;
      nxt_st.view = st_ff.gpr[view_sel];
      // Only outside writers touch the flags; no transfer here does
      if (flags_wr) begin
         nxt_st.flags = flags_wdata;
      end
      if (stall_now) begin
         nxt_st.stall_cnt = st_ff.stall_cnt + 16'h0001;
      end
      unique case (st_ff.st)
         CDT_ST_IDLE: begin
            // The interlock lasts exactly one idle cycle
            nxt_st.haz_v = 1'b0;
            if (take) begin
               nxt_st.op = d;
               case (d.kind)
                  CDT_K_IMM: begin
                     nxt_st.gpr[d.dst] = d.disp;
                     nxt_st.done = 1'b1;
                  end
                  CDT_K_COPY: begin
                     nxt_st.gpr[d.dst] = st_ff.gpr[d.src];
                     nxt_st.done = 1'b1;
                  end
                  CDT_K_LOAD, CDT_K_STORE: begin
                     nxt_st.addr = eff_addr;
                     nxt_st.size = d.size;
                     nxt_st.we = (d.kind == CDT_K_STORE);
                     // Data is taken before any base update, so a store of
                     // the base register itself writes its old value
                     nxt_st.wdata = st_ff.gpr[d.src];
                     if (d.pre_dec) begin
                        nxt_st.gpr[d.base] = eff_addr;
                     end
                     if (d.post_inc) begin
                        nxt_st.gpr[d.base] = base_val + step;
                     end
                     if (fetch_busy) begin
                        nxt_st.st = CDT_ST_WAIT;
                     end else begin
                        nxt_st.req = 1'b1;
                        nxt_st.st = CDT_ST_MEM;
                     end
                  end
                  default: begin
                     nxt_st.illegal = 1'b1;
                  end
               endcase
            end
         end
         CDT_ST_WAIT: begin
            // Instruction fetch owns the bus this cycle
            if (!fetch_busy) begin
               nxt_st.req = 1'b1;
               nxt_st.st = CDT_ST_MEM;
            end
         end
         CDT_ST_MEM: begin
            // Request stands until the bus answers; wait states stretch here
            if (mem_ack) begin
               nxt_st.req = 1'b0;
               nxt_st.we = 1'b0;
               nxt_st.done = 1'b1;
               nxt_st.st = CDT_ST_IDLE;
               if (st_ff.op.kind == CDT_K_LOAD) begin
                  // Load wins over a post-increment of the same register
                  nxt_st.gpr[st_ff.op.dst] = cdt_sext(mem_rdata, st_ff.op.size);
                  nxt_st.haz_v = 1'b1;
                  nxt_st.haz_reg = st_ff.op.dst;
               end
            end
         end
         default: begin
            nxt_st.req = 1'b0;
            nxt_st.st = CDT_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_ff <= '0;
         st_ff.st <= CDT_ST_IDLE;
         st_ff.gpr <= {16{`CDT_GPR_RST}};
         st_ff.flags <= `CDT_FLAGS_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs
   assign instr_done = st_ff.done;
   assign instr_illegal = st_ff.illegal;
   assign mem_req = st_ff.req;
   assign mem_we = st_ff.we;
   assign mem_addr = st_ff.addr;
   assign mem_size = st_ff.size;
   assign mem_wdata = st_ff.wdata;
   assign flags_word = st_ff.flags;
   assign view_data = st_ff.view;
   assign data_stall = stall_now;
   assign stall_count = st_ff.stall_cnt;
endmodule
`default_nettype wire

// >>> verif/cdt_core_asserts.sv
// Port-level properties of the data-transfer execute unit
`timescale 1ns/100ps
`default_nettype none
module cdt_core_asserts (
   // Clock and reset
   input wire logic               clk_sys,
   input wire logic               nrst,
   // Issue and retire
   input wire logic               instr_valid,
   input wire logic [15:0]        instr_word,
   input wire logic [31:0]        instr_pc,
   input wire logic               instr_ready,
   input wire logic               instr_done,
   // Bus and status
   input wire logic               mem_req,
   input wire logic               mem_we,
   input wire logic [31:0]        mem_addr,
   input wire cdt_pkg::cdt_size_t mem_size,
   input wire logic               mem_ack,
   input wire logic               fetch_busy,
   input wire logic               flags_wr,
   input wire logic [31:0]        flags_word,
   input wire logic               data_stall,
   input wire logic [15:0]        stall_count
);
   import cdt_pkg::*;
   logic        take;
   logic [31:0] pc_exp_ff;
   assign take = instr_valid && instr_ready;
   // Expected PC-relative address, held one cycle to meet the request
   always_ff @(posedge clk_sys) begin
      pc_exp_ff <= instr_pc + ((instr_word[15:12] == 4'hD) ? {22'h0, instr_word[7:0], 2'h0}
                                                          : {23'h0, instr_word[7:0], 1'h0});
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   AST_PC_WORD: assert property (
      take && !fetch_busy && instr_word[15:12] == 4'h9 |=> mem_req && mem_addr == pc_exp_ff && mem_size == CDT_SIZE_WORD)
      else $error("PC word load address or size wrong");
   AST_PC_LONG: assert property (
      take && !fetch_busy && instr_word[15:12] == 4'hD |=> mem_req && mem_addr == pc_exp_ff && mem_size == CDT_SIZE_LONG)
      else $error("PC longword load address or size wrong");
   AST_IMM_ONE: assert property (take && instr_word[15:12] == 4'hE |=> instr_done)
      else $error("Immediate load did not retire in one state");
   AST_FLAGS: assert property (!flags_wr |=> $stable(flags_word))
      else $error("Flags word changed by a transfer");
   AST_REQ_HOLD: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_size) && $stable(mem_we))
      else $error("Request changed during wait state");
   AST_REQ_END: assert property (mem_req && mem_ack |=> !mem_req && instr_done)
      else $error("Access did not end after answer");
   AST_NO_RISE: assert property ($rose(mem_req) |-> !$past(fetch_busy))
      else $error("Request raised during fetch");
   AST_BUSY: assert property (mem_req |-> !instr_ready)
      else $error("Issue accepted during access");
   AST_WAIT: assert property (mem_req && !mem_ack |-> data_stall)
      else $error("Wait state not flagged as stall");
   AST_STALL_CNT: assert property (data_stall |=> stall_count == $past(stall_count) + 16'h1)
      else $error("Stall counter did not step");
endmodule
bind cdt_core cdt_core_asserts cdt_core_asserts_inst (.clk_sys, .nrst, .instr_valid, .instr_word, .instr_pc,
   .instr_ready, .instr_done, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_ack, .fetch_busy, .flags_wr,
   .flags_word, .data_stall, .stall_count);
`default_nettype wire

// >>> verif/cdt_mem_model.sv
// Behavioural data memory answering the execute unit's bus
`timescale 1ns/100ps
`default_nettype none
module cdt_mem_model (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // Data bus
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata,
   // Wait states before each answer
   input  wire logic [3:0]  wait_n
);
   logic [3:0]  cnt_ff;
   logic [31:0] junk_ff;
   always_ff @(posedge clk_sys) begin
      if (!nrst || !mem_req || mem_ack) begin
         cnt_ff <= 4'h0;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
      junk_ff <= nrst ? junk_ff + 32'h9E37_79B9 : 32'h5A5A_A5A5;
   end
   assign mem_ack = mem_req && (cnt_ff == wait_n);
   // Data is the inverted address; between answers it churns so a late sample is caught
   assign mem_rdata = mem_ack ? ~mem_addr : junk_ff;
endmodule
`default_nettype wire

// >>> verif/cdt_core_test.sv
// Self-checking bench for the data-transfer execute unit
`timescale 1ns/100ps
`default_nettype none
module cdt_core_test;
   import cdt_pkg::*;
   logic        clk_sys, nrst, instr_valid, instr_ready, instr_done, instr_illegal;
   logic        mem_req, mem_we, mem_ack, fetch_busy, flags_wr, data_stall;
   logic [15:0] instr_word, stall_count;
   logic [31:0] instr_pc, mem_addr, mem_wdata, mem_rdata, flags_wdata, flags_word, view_data;
   logic [3:0]  view_sel, wait_n;
   cdt_size_t   mem_size;
   int          err_count, total_checks;
   cdt_core cdt_core_inst (.clk_sys, .nrst, .instr_valid, .instr_word, .instr_pc, .instr_ready, .instr_done,
      .instr_illegal, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata, .mem_ack, .mem_rdata, .fetch_busy,
      .flags_wr, .flags_wdata, .flags_word, .view_sel, .view_data, .data_stall, .stall_count);
   cdt_mem_model cdt_mem_model_inst (.clk_sys, .nrst, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .wait_n);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0d ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Valid stays up on return so words can follow back to back
   // Ready is read at the falling edge, where it has settled for the coming rising edge
   task automatic issue(input logic [15:0] w, output int n);
      logic rdy;
      n = 0;
      instr_valid = 1'b1;
      instr_word = w;
      do begin
         @(negedge clk_sys);
         rdy = instr_ready;
         @(posedge clk_sys);
         n++;
      end while (!rdy && n < 50);
      #1;
   endtask
   task automatic rreg(input logic [3:0] r, input logic [31:0] exp);
      instr_valid = 1'b0;
      view_sel = r;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(view_data, exp);
   endtask
   task automatic mop(input logic [15:0] w, input logic [31:0] a, input logic [1:0] s, input logic we,
                      input logic [31:0] wd);
      int n;
      issue(w, n);
      instr_valid = 1'b0;
      if (fetch_busy) begin
         repeat (2) @(negedge clk_sys) chk(32'(mem_req), 32'h0);
         @(posedge clk_sys);
         #1 fetch_busy = 1'b0;
      end
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (!(mem_req && mem_ack) && n < 50);
      chk(mem_addr, a);
      chk(32'(mem_size), 32'(s));
      chk(32'(mem_we), 32'(we));
      if (we) chk(mem_wdata, wd);
      @(negedge clk_sys);
      chk(32'(instr_done), 32'h1);
      @(posedge clk_sys);
      #1;
   endtask
   task automatic t_imm();
      int n;
      issue(16'hE17F, n);
      issue(16'hE280, n);
      issue(16'hEF55, n);
      issue(16'hE010, n);
      issue(16'h6313, n);
      chk(32'(n), 32'h1);
      issue(16'h3123, n);
      instr_valid = 1'b0;
      @(negedge clk_sys);
      chk(32'(instr_illegal), 32'h1);
      @(posedge clk_sys);
      #1;
      rreg(4'h1, 32'h7F);
      rreg(4'h2, 32'hFFFF_FF80);
      rreg(4'hF, 32'h55);
      rreg(4'h0, 32'h10);
      rreg(4'h3, 32'h7F);
      $display("t_imm finished");
   endtask
   task automatic t_pcrel();
      logic [15:0] sc;
      instr_pc = 32'h100;
      wait_n = 4'h2;
      sc = stall_count;
      mop(16'h9581, 32'h202, 2'h1, 1'b0, 32'h0);
      chk(32'(stall_count - sc), 32'h2);
      wait_n = 4'h0;
      fetch_busy = 1'b1;
      mop(16'hD603, 32'h10C, 2'h2, 1'b0, 32'h0);
      mop(16'hD7FF, 32'h4FC, 2'h2, 1'b0, 32'h0);
      rreg(4'h5, 32'hFFFF_FDFD);
      rreg(4'h6, 32'hFFFF_FEF3);
      $display("t_pcrel finished");
   endtask
   task automatic t_regind();
      mop(16'h6710, 32'h7F, 2'h0, 1'b0, 32'h0);
      mop(16'h6826, 32'hFFFF_FF80, 2'h2, 1'b0, 32'h0);
      mop(16'h6915, 32'h7F, 2'h1, 1'b0, 32'h0);
      rreg(4'h7, 32'hFFFF_FF80);
      rreg(4'h8, 32'h7F);
      rreg(4'h2, 32'hFFFF_FF84);
      rreg(4'h9, 32'hFFFF_FF80);
      rreg(4'h1, 32'h81);
      $display("t_regind finished");
   endtask
   task automatic t_store();
      mop(16'h2F36, 32'h51, 2'h2, 1'b1, 32'h7F);
      mop(16'h8035, 32'h84, 2'h0, 1'b1, 32'h10);
      mop(16'h8135, 32'h89, 2'h1, 1'b1, 32'h10);
      mop(16'h101F, 32'h4C, 2'h2, 1'b1, 32'h81);
      for (int i = 0; i < 3; i++) begin
         mop(16'h03F4 + 16'(i), 32'h8F, 2'(i), 1'b1, 32'h51);
      end
      rreg(4'hF, 32'h51);
      mop(16'h2F35, 32'h4F, 2'h1, 1'b1, 32'h7F);
      mop(16'h2310, 32'h7F, 2'h0, 1'b1, 32'h81);
      rreg(4'hF, 32'h4F);
      $display("t_store finished");
   endtask
   task automatic t_dload();
      mop(16'h8431, 32'h80, 2'h0, 1'b0, 32'h0);
      mop(16'h8532, 32'h83, 2'h1, 1'b0, 32'h0);
      mop(16'h5A3F, 32'hBB, 2'h2, 1'b0, 32'h0);
      rreg(4'h0, 32'hFFFF_FF7C);
      rreg(4'hA, 32'hFFFF_FF44);
      $display("t_dload finished");
   endtask
   task automatic t_hazard();
      int n;
      issue(16'h6B12, n);
      issue(16'h6CB3, n);
      chk(32'(n), 32'h3);
      rreg(4'hC, 32'hFFFF_FF7E);
      $display("t_hazard finished");
   endtask
   initial begin
      nrst = 1'b0;
      instr_valid = 1'b0;
      fetch_busy = 1'b0;
      flags_wr = 1'b0;
      instr_word = 16'h0;
      instr_pc = 32'h0;
      flags_wdata = 32'h0;
      view_sel = 4'h0;
      wait_n = 4'h0;
      err_count = 0;
      total_checks = 0;
      repeat (3) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      flags_wr = 1'b1;
      flags_wdata = 32'hA5;
      @(posedge clk_sys);
      #1;
      flags_wr = 1'b0;
      t_imm();
      t_pcrel();
      t_regind();
      t_store();
      t_dload();
      t_hazard();
      chk(flags_word, 32'hA5);
      results();
   end
   // The whole run needs well under a thousand cycles
   initial begin
      #20000;
      err_count++;
      results();
   end
endmodule
`default_nettype wire
